// ===== hw/srwdt_pkg.sv
// How it works
// - Power-on reset hold chosen by two bits: 50, 200, 400 or 800 ms.
// - Watchdog period chosen by two bits: 1.4 s, 200 ms, 25 ms or off.
// - Watchdog expiry at codes 00/01 holds reset about 200 ms.
// - Watchdog expiry at code 10 holds reset about 25 ms.
// - Nonvolatile write finishes within 10 ms after the ending stop.
// - Manual reset pulses shorter than 50 ns are ignored.
// - Manual reset activation reaches reset no sooner than 500 ns.
// - On supply loss the warning leads reset by about 500 ns.
// - Serial bus input glitches under 50 ns are rejected.
// - Wrong device select returns the bus to standby nine clocks after start.
`default_nettype none

package srwdt_pkg;

    // ----------------------------------------
    // Clock and time base
    // ----------------------------------------
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 500000;
    localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
    localparam int TICK_W = 14;
    localparam int TICKS_PER_MS = 1000000 / TICK_NS;
    localparam int DLY_W = 12;

    // ----------------------------------------
    // Delays in ms and in ticks
    // ----------------------------------------
    localparam int POR_50_MS = 50;
    localparam int POR_200_MS = 200;
    localparam int POR_400_MS = 400;
    localparam int POR_800_MS = 800;
    localparam int WD_1400_MS = 1400;
    localparam int WD_200_MS = 200;
    localparam int WD_25_MS = 25;
    localparam int WD_RST_LONG_MS = 200;
    localparam int WD_RST_SHORT_MS = 25;
    localparam int NV_WC_TYP_MS = 5;
    localparam logic [DLY_W-1:0] POR_T0 = DLY_W'(POR_50_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] POR_T1 = DLY_W'(POR_200_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] POR_T2 = DLY_W'(POR_400_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] POR_T3 = DLY_W'(POR_800_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] WD_T0 = DLY_W'(WD_1400_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] WD_T1 = DLY_W'(WD_200_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] WD_T2 = DLY_W'(WD_25_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] WDR_LONG_T = DLY_W'(WD_RST_LONG_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] WDR_SHORT_T = DLY_W'(WD_RST_SHORT_MS * TICKS_PER_MS);
    localparam logic [DLY_W-1:0] NV_WC_T = DLY_W'(NV_WC_TYP_MS * TICKS_PER_MS);

    // ----------------------------------------
    // Short delays in cycles
    // ----------------------------------------
    localparam int MR_DLY_NS = 500;
    localparam int LOW_LEAD_NS = 500;
    localparam logic [3:0] MR_DLY_CYC = 4'((MR_DLY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] LOW_LEAD_CYC = 4'(LOW_LEAD_NS / CLK_NS);
    localparam logic [3:0] SEL_CLKS = 4'h9;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [1:0] WD_OFF_CODE = 2'h3;
    localparam logic [1:0] WD_SHORT_CODE = 2'h2;

    typedef struct packed {
        logic wdog_period_sel_hi;
        logic wdog_period_sel_lo;
        logic por_delay_sel_hi;
        logic por_delay_sel_lo;
    } srwdt_ctrl_t;

    localparam srwdt_ctrl_t CTRL_RST = 4'hD;

    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_RUN = 2'b01,
        ST_WDR = 2'b11
    } srwdt_state_t;

endpackage : srwdt_pkg

`default_nettype wire

// ===== hw/srwdt_top.sv
`default_nettype none

module srwdt_top
    import srwdt_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_fail_in,
    input wire logic manual_reset_in_n,
    input wire logic wdog_restart_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sel_match_in,
    input wire logic wr_seq_in,
    output logic reset_out,
    output logic supply_low_warning,
    output logic nv_busy,
    output logic bus_active
);

    // ----------------------------------------
    // Input glitch filters
    // ----------------------------------------
    logic [2:0] raw;
    logic [2:0] last_ff;
    logic [2:0] filt_ff;
    logic [2:0] nxt_filt;
    assign raw = {manual_reset_in_n, sda_in, scl_in};

    // Output follows only values seen on two samples in a row
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            nxt_filt[i] = (raw[i] == last_ff[i]) ? raw[i] : filt_ff[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_ff <= 3'h7;
            filt_ff <= 3'h7;
        end
        else
        begin
            last_ff <= raw;
            filt_ff <= nxt_filt;
        end
    end

    // ----------------------------------------
    // Time base and short delays
    // ----------------------------------------
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TICK_W-1:0] nxt_tick_cnt;
    logic tick;
    logic [3:0] mr_cnt_ff;
    logic [3:0] nxt_mr_cnt;
    logic [3:0] low_cnt_ff;
    logic [3:0] nxt_low_cnt;
    logic warn_ff;
    logic mr_hit;
    logic low_hit;

    assign tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));
    assign mr_hit = (mr_cnt_ff == MR_DLY_CYC);
    assign low_hit = (low_cnt_ff == LOW_LEAD_CYC);

    always_comb
    begin
        nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
        nxt_mr_cnt = '0;
        if (!filt_ff[2])
        begin
            nxt_mr_cnt = mr_hit ? mr_cnt_ff : mr_cnt_ff + 1'b1;
        end
        nxt_low_cnt = '0;
        if (supply_fail_in)
        begin
            nxt_low_cnt = low_hit ? low_cnt_ff : low_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_ff <= '0;
            mr_cnt_ff <= '0;
            low_cnt_ff <= '0;
            warn_ff <= 1'b0;
        end
        else
        begin
            tick_cnt_ff <= nxt_tick_cnt;
            mr_cnt_ff <= nxt_mr_cnt;
            low_cnt_ff <= nxt_low_cnt;
            warn_ff <= supply_fail_in;
        end
    end

    // ----------------------------------------
    // Reset sequencer and watchdog
    // ----------------------------------------
    srwdt_ctrl_t ctrl_ff;
    srwdt_state_t st_ff;
    srwdt_state_t nxt_st;
    logic [DLY_W-1:0] del_ff;
    logic [DLY_W-1:0] nxt_del;
    logic [DLY_W-1:0] wd_ff;
    logic [DLY_W-1:0] nxt_wd;
    logic kick_ff;
    logic wdr_flag_ff;
    logic nxt_wdr_flag;
    logic [DLY_W-1:0] por_lim;
    logic [DLY_W-1:0] wd_lim;
    logic [DLY_W-1:0] wdr_lim;
    logic [1:0] wd_code;
    logic hold;
    logic wd_exp;
    logic flag_clr;

    assign wd_code = {ctrl_ff.wdog_period_sel_hi, ctrl_ff.wdog_period_sel_lo};
    assign hold = mr_hit || low_hit;
    assign wd_exp = (wd_code != WD_OFF_CODE) && (wd_ff >= wd_lim);

    always_comb
    begin
        case ({ctrl_ff.por_delay_sel_hi, ctrl_ff.por_delay_sel_lo})
            2'h0: por_lim = POR_T0;
            2'h1: por_lim = POR_T1;
            2'h2: por_lim = POR_T2;
            default: por_lim = POR_T3;
        endcase
        case (wd_code)
            2'h0: wd_lim = WD_T0;
            2'h1: wd_lim = WD_T1;
            default: wd_lim = WD_T2;
        endcase
        wdr_lim = (wd_code == WD_SHORT_CODE) ? WDR_SHORT_T : WDR_LONG_T;
        nxt_st = st_ff;
        nxt_del = tick ? del_ff + 1'b1 : del_ff;
        nxt_wd = '0;
        nxt_wdr_flag = wdr_flag_ff && !flag_clr;
        case (st_ff)
            ST_POR:
            begin
                if (hold)
                begin
                    nxt_del = '0;
                end
                else if (del_ff >= por_lim)
                begin
                    nxt_st = ST_RUN;
                    nxt_del = '0;
                end
            end
            ST_RUN:
            begin
                nxt_wd = tick ? wd_ff + 1'b1 : wd_ff;
                if ((kick_ff != wdog_restart_in && wdog_restart_in) || wd_code == WD_OFF_CODE)
                begin
                    nxt_wd = '0;
                end
                nxt_del = '0;
                if (hold)
                begin
                    nxt_st = ST_POR;
                end
                else if (wd_exp)
                begin
                    nxt_st = ST_WDR;
                    nxt_wdr_flag = 1'b1;
                end
            end
            ST_WDR:
            begin
                if (hold)
                begin
                    nxt_st = ST_POR;
                    nxt_del = '0;
                end
                else if (del_ff >= wdr_lim)
                begin
                    nxt_st = ST_RUN;
                    nxt_del = '0;
                end
            end
            default:
            begin
                nxt_st = ST_POR;
                nxt_del = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= ST_POR;
            del_ff <= '0;
            wd_ff <= '0;
            kick_ff <= 1'b0;
            wdr_flag_ff <= 1'b0;
            reset_out <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            del_ff <= nxt_del;
            wd_ff <= nxt_wd;
            kick_ff <= wdog_restart_in;
            wdr_flag_ff <= nxt_wdr_flag;
            reset_out <= (nxt_st != ST_RUN);
        end
    end

    assign supply_low_warning = warn_ff;

    // ----------------------------------------
    // Serial bus activity and write cycle
    // ----------------------------------------
    logic scl_d_ff;
    logic sda_d_ff;
    logic act_ff;
    logic nxt_act;
    logic [3:0] clk_cnt_ff;
    logic [3:0] nxt_clk_cnt;
    logic [DLY_W-1:0] nv_ff;
    logic [DLY_W-1:0] nxt_nv;
    logic start_det;
    logic stop_det;
    logic scl_rise;

    assign start_det = filt_ff[0] && scl_d_ff && sda_d_ff && !filt_ff[1];
    assign stop_det = filt_ff[0] && scl_d_ff && !sda_d_ff && filt_ff[1];
    assign scl_rise = filt_ff[0] && !scl_d_ff;

    always_comb
    begin
        nxt_act = act_ff;
        nxt_clk_cnt = clk_cnt_ff;
        nxt_nv = (nv_ff != '0 && tick) ? nv_ff - 1'b1 : nv_ff;
        if (start_det)
        begin
            nxt_act = 1'b1;
            nxt_clk_cnt = '0;
        end
        else if (stop_det)
        begin
            nxt_act = 1'b0;
            if (act_ff && wr_seq_in)
            begin
                nxt_nv = NV_WC_T;
            end
        end
        else if (act_ff && scl_rise && clk_cnt_ff != SEL_CLKS)
        begin
            nxt_clk_cnt = clk_cnt_ff + 1'b1;
            if (clk_cnt_ff + 1'b1 == SEL_CLKS && !sel_match_in)
            begin
                nxt_act = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            act_ff <= 1'b0;
            clk_cnt_ff <= '0;
            nv_ff <= '0;
            nv_busy <= 1'b0;
        end
        else
        begin
            scl_d_ff <= filt_ff[0];
            sda_d_ff <= filt_ff[1];
            act_ff <= nxt_act;
            clk_cnt_ff <= nxt_clk_cnt;
            nv_ff <= nxt_nv;
            nv_busy <= (nxt_nv != '0);
        end
    end

    assign bus_active = act_ff;

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    srwdt_ctrl_t nxt_ctrl;
    logic [31:0] nxt_rdata;
    logic acc;
    logic hit_ctrl;
    logic hit_stat;

    assign acc = psel && penable;
    assign hit_ctrl = (paddr == CTRL_OFF);
    assign hit_stat = (paddr == STAT_OFF);
    assign pready = 1'b1;
    assign pslverr = acc && !hit_ctrl && !hit_stat;
    assign flag_clr = acc && pwrite && hit_stat && pwdata[4];

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (acc && pwrite && hit_ctrl)
        begin
            nxt_ctrl = srwdt_ctrl_t'(pwdata[3:0]);
        end
        nxt_rdata = '0;
        if (psel && !penable && !pwrite && hit_ctrl)
        begin
            nxt_rdata = {28'h0, ctrl_ff};
        end
        else if (psel && !penable && !pwrite && hit_stat)
        begin
            nxt_rdata = {27'h0, wdr_flag_ff, act_ff, nv_busy, warn_ff, reset_out};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= CTRL_RST;
            prdata <= '0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            prdata <= nxt_rdata;
        end
    end

endmodule : srwdt_top

`default_nettype wire

// ===== sim/srwdt_checker.sv
`default_nettype none
module srwdt_checker
    import srwdt_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic supply_fail_in,
    input wire logic manual_reset_in_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sel_match_in,
    input wire logic reset_out,
    input wire logic supply_low_warning,
    input wire logic nv_busy,
    input wire logic bus_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----
    // Interval counters
    // ----
    int hi_ff;
    int nxt_hi;
    int busy_ff;
    int nxt_busy;
    logic [3:0] scl_n_ff;
    logic [3:0] nxt_scl_n;
    logic scl_d_ff;
    always_comb
    begin
        nxt_hi = reset_out ? hi_ff + 1 : 0;
        nxt_busy = nv_busy ? busy_ff + 1 : 0;
        nxt_scl_n = bus_active ? scl_n_ff + 4'(scl_in && !scl_d_ff) : 4'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hi_ff <= 0;
            busy_ff <= 0;
            scl_n_ff <= 4'h0;
            scl_d_ff <= 1'b1;
        end
        else
        begin
            hi_ff <= nxt_hi;
            busy_ff <= nxt_busy;
            scl_n_ff <= nxt_scl_n;
            scl_d_ff <= scl_in;
        end
    end
    // ----
    // Properties
    // ----
    sequence quiet_s;
        !reset_out [*8] ##1 !reset_out [*2];
    endsequence
    sequence mr_held_s;
        $fell(manual_reset_in_n) ##1 !manual_reset_in_n [*8];
    endsequence
    warn_lead_a: assert property ($rose(supply_low_warning) && !reset_out |->
        quiet_s ##[1:8] reset_out) else $error("reset not after warning");
    mr_delay_a: assert property ($fell(manual_reset_in_n) && !reset_out |-> quiet_s)
        else $error("manual reset too early");
    mr_glitch_a: assert property (!reset_out && $fell(manual_reset_in_n) ##1
        manual_reset_in_n |-> quiet_s ##1 !reset_out [*4]) else $error("short pulse taken");
    mr_take_a: assert property (mr_held_s |-> ##[1:8] reset_out)
        else $error("manual reset missed");
    rst_min_a: assert property ($fell(reset_out) |-> hi_ff >= 49 * TICK_CYC)
        else $error("reset hold too short");
    rst_max_a: assert property (reset_out |-> hi_ff < 1605 * TICK_CYC)
        else $error("reset hold too long");
    nv_max_a: assert property (nv_busy |-> busy_ff < 20 * TICK_CYC)
        else $error("write cycle too long");
    nv_typ_a: assert property ($fell(nv_busy) |-> busy_ff >= 9 * TICK_CYC)
        else $error("write cycle too short");
    bus_glitch_a: assert property (!bus_active && scl_in && $fell(sda_in) ##1 sda_in
        |-> !bus_active [*4]) else $error("glitch seen as start");
    sel_drop_a: assert property (bus_active && scl_n_ff == 4'h9 && !sel_match_in
        |-> ##[1:6] !bus_active) else $error("no standby after bad select");
endmodule : srwdt_checker

bind srwdt_top srwdt_checker #(.TICK_CYC(TICK_CYC)) u_srwdt_checker (.pclk, .presetn,
    .supply_fail_in, .manual_reset_in_n, .scl_in, .sda_in, .sel_match_in, .reset_out,
    .supply_low_warning, .nv_busy, .bus_active);
`default_nettype wire

// ===== sim/srwdt_host.sv
`default_nettype none
module srwdt_host
    import srwdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic kick_req,
    output logic wdog_restart_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Restart pulse of at least 1 us
    // ----
    localparam int PULSE_CYC = 1000 / CLK_NS + 1;
    int left_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left_ff <= 0;
        end
        else if (kick_req)
        begin
            left_ff <= PULSE_CYC;
        end
        else if (left_ff > 0)
        begin
            left_ff <= left_ff - 1;
        end
    end
    assign wdog_restart_in = left_ff > 0;
endmodule : srwdt_host
`default_nettype wire

// ===== sim/srwdt_top_tb.sv
`default_nettype none
module srwdt_top_tb
    import srwdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 10;
    localparam int TOL = 15;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic supply_fail_in, manual_reset_in_n, wdog_restart_in, kick_req;
    logic scl_in, sda_in, sel_match_in, wr_seq_in, e;
    logic reset_out, supply_low_warning, nv_busy, bus_active;
    int fails, checked, n, cyc, x;
    int por_ms[4] = '{50, 200, 400, 800};
    logic [1:0] wd_c[3] = '{2'h2, 2'h1, 2'h0};
    int wd_ms[3] = '{25, 200, 1400};
    int wr_ms[3] = '{25, 200, 200};
    srwdt_top #(.TICK_CYC(TC)) u_srwdt_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_fail_in, .manual_reset_in_n,
        .wdog_restart_in, .scl_in, .sda_in, .sel_match_in, .wr_seq_in, .reset_out,
        .supply_low_warning, .nv_busy, .bus_active);
    srwdt_host u_srwdt_host (.pclk, .presetn, .kick_req, .wdog_restart_in);
    // ----
    // Tasks
    // ----
    task automatic summarize();
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_rng(input int v, input int lo, input int hi);
        checked++;
        if (v < lo || v > hi)
        begin
            fails++;
            $display("[ERR] %0t count %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask : cmp_rng
    task automatic step(input int k);
        repeat (k) @(posedge pclk);
    endtask : step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic pick(input int s);
        return s == 0 ? reset_out : s == 1 ? bus_active : s == 2 ? nv_busy : supply_low_warning;
    endfunction : pick
    task automatic meas(input int s, input logic v);
        n = 0;
        while (pick(s) !== v && n < 40000)
        begin
            n++;
            @(posedge pclk);
        end
    endtask : meas
    task automatic kick();
        kick_req <= 1'b1;
        step(1);
        kick_req <= 1'b0;
        step(1);
    endtask : kick
    task automatic bus(input logic c, input logic d);
        scl_in <= c;
        sda_in <= d;
        step(10);
    endtask : bus
    // ----
    // Clock, timeout and tests
    // ----
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fails++;
            summarize();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, kick_req} = '0;
        {supply_fail_in, sel_match_in, wr_seq_in} = '0;
        {manual_reset_in_n, scl_in, sda_in} = 3'h7;
        step(12);
        presetn <= 1'b1;
        meas(0, 1'b0);
        cmp_rng(n, 4000 - TOL, 4000 + TOL);
        apb(1'b0, CTRL_OFF, 32'h0);
        cmp(q, 32'h0000000D);
        apb(1'b0, 12'h010, 32'h0);
        cmp({31'h0, e}, 32'h1);
        manual_reset_in_n <= 1'b0;
        step(1);
        manual_reset_in_n <= 1'b1;
        step(30);
        cmp({31'h0, reset_out}, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, CTRL_OFF, {28'h0, 2'h3, 2'(c)});
            manual_reset_in_n <= 1'b0;
            meas(0, 1'b1);
            cmp_rng(n, 10, 20);
            step(30);
            manual_reset_in_n <= 1'b1;
            meas(0, 1'b0);
            x = por_ms[c] * TICKS_PER_MS * TC;
            cmp_rng(n, x - TOL, x + TOL);
        end
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, CTRL_OFF, {28'h0, wd_c[i], 2'h0});
            kick();
            step(100);
            kick();
            meas(0, 1'b1);
            x = wd_ms[i] * TICKS_PER_MS * TC;
            cmp_rng(n, x - TOL, x + TOL);
            meas(0, 1'b0);
            x = wr_ms[i] * TICKS_PER_MS * TC;
            cmp_rng(n, x - TOL, x + TOL);
        end
        apb(1'b0, STAT_OFF, 32'h0);
        cmp(q, 32'h00000010);
        apb(1'b1, STAT_OFF, 32'h00000010);
        apb(1'b0, STAT_OFF, 32'h0);
        cmp(q, 32'h00000000);
        apb(1'b1, CTRL_OFF, 32'h0000000C);
        supply_fail_in <= 1'b1;
        meas(3, 1'b1);
        cmp_rng(n, 1, 3);
        meas(0, 1'b1);
        cmp_rng(n, 9, 14);
        step(20);
        supply_fail_in <= 1'b0;
        meas(0, 1'b0);
        cmp_rng(n, 1000 - TOL, 1000 + TOL);
        sda_in <= 1'b0;
        step(1);
        sda_in <= 1'b1;
        step(10);
        cmp({31'h0, bus_active}, 32'h0);
        bus(1'b1, 1'b0);
        for (int b = 0; b < 8; b++)
        begin
            bus(1'b0, 1'b0);
            bus(1'b1, 1'b0);
        end
        cmp({31'h0, bus_active}, 32'h1);
        bus(1'b0, 1'b0);
        scl_in <= 1'b1;
        meas(1, 1'b0);
        cmp_rng(n, 1, 6);
        sel_match_in <= 1'b1;
        wr_seq_in <= 1'b1;
        bus(1'b1, 1'b1);
        bus(1'b1, 1'b0);
        bus(1'b0, 1'b0);
        bus(1'b1, 1'b0);
        sda_in <= 1'b1;
        meas(2, 1'b1);
        cmp_rng(n, 1, 6);
        meas(2, 1'b0);
        cmp_rng(n, 10 * TC - TOL, 10 * TC + TOL);
        summarize();
    end
endmodule : srwdt_top_tb
`default_nettype wire
